/* rtl/cps_pkg.sv */
package cps_pkg;

  localparam int          CPS_PC_W        = 11;
  localparam int          CPS_STACK_DEPTH = 4;
  localparam int          CPS_IW          = 16;
  localparam int          CPS_RA_W        = 4;

  localparam logic [3:0]  CPS_OFS_PCL     = 4'h0;
  localparam logic [3:0]  CPS_OFS_ACC     = 4'h1;
  localparam logic [3:0]  CPS_OFS_STATUS  = 4'h2;

  localparam logic [7:0]  CPS_ACC_RST     = 8'h00;
  localparam logic [3:0]  CPS_FLAGS_RST   = 4'h0;
  localparam logic [15:0] CPS_RESET_VEC   = 16'h0000;
  localparam logic [15:0] CPS_IRQ_VEC     = 16'h0004;
  localparam logic [15:0] CPS_NOP_WORD    = 16'h0000;

  localparam int          CPS_ST_C        = 0;
  localparam int          CPS_ST_AC       = 1;
  localparam int          CPS_ST_Z        = 2;
  localparam int          CPS_ST_OV       = 3;
  localparam int          CPS_ST_FULL     = 4;
  localparam int          CPS_ST_ISR      = 5;

  localparam logic [3:0]  CPS_UPD_NONE    = 4'h0;
  localparam logic [3:0]  CPS_UPD_C       = 4'h1;
  localparam logic [3:0]  CPS_UPD_Z       = 4'h4;
  localparam logic [3:0]  CPS_UPD_ALL     = 4'hF;

  typedef enum logic [1:0] {CPS_T1, CPS_T2, CPS_T3, CPS_T4} cps_phase_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_ALU, OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT_INSTR, OP_SKIP, OP_MOVPCL
  } cps_opc_t;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
    ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_MOV
  } cps_aluop_t;

endpackage

/* rtl/cps_alu_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cps_alu_if;
  import cps_pkg::*;
  cps_aluop_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic       acin;
  logic [7:0] result;
  logic [3:0] flags;
  logic [3:0] upd;

  modport core (output op, a, b, cin, acin, input result, flags, upd);
  modport alu  (input op, a, b, cin, acin, output result, flags, upd);
endinterface
`default_nettype wire

/* rtl/cps_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_alu
  import cps_pkg::*;
(
  cps_alu_if.alu bus  // operands in, result and flags out
);
  logic       is_sub;
  logic [7:0] bb;
  logic       ci;
  logic [8:0] sum9;
  logic [4:0] nib;
  logic       lo_adj;
  logic       hi_adj;
  logic [8:0] daa9;

  assign is_sub = (bus.op == ALU_SUB) || (bus.op == ALU_SBC);
  assign bb     = is_sub ? ~bus.b : bus.b;
  // carry in doubles as not-borrow for subtraction
  assign ci     = (bus.op == ALU_SUB) ? 1'b1 :
                  ((bus.op == ALU_ADC) || (bus.op == ALU_SBC)) ? bus.cin : 1'b0;
  assign sum9   = {1'b0, bus.a} + {1'b0, bb} + {8'h00, ci};
  assign nib    = {1'b0, bus.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
  assign lo_adj = (bus.a[3:0] > 4'h9) || bus.acin;
  assign hi_adj = (bus.a[7:4] > 4'h9) || bus.cin || ((bus.a[7:4] == 4'h9) && (bus.a[3:0] > 4'h9));
  assign daa9   = {1'b0, bus.a} + {1'b0, hi_adj ? 4'h6 : 4'h0, lo_adj ? 4'h6 : 4'h0};

  always_comb begin
    bus.result = bus.a;
    bus.flags  = 4'h0;
    bus.upd    = CPS_UPD_NONE;
    case (bus.op)
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
        bus.result = sum9[7:0];
        bus.flags[CPS_ST_C]  = sum9[8];
        bus.flags[CPS_ST_AC] = nib[4];
        bus.flags[CPS_ST_OV] = (bus.a[7] == bb[7]) && (sum9[7] != bus.a[7]);
        bus.upd    = CPS_UPD_ALL;
      end
      ALU_DAA: begin
        bus.result = daa9[7:0];
        bus.flags[CPS_ST_C] = bus.cin | daa9[8] | hi_adj;
        bus.upd    = CPS_UPD_C;
      end
      ALU_AND: begin bus.result = bus.a & bus.b; bus.upd = CPS_UPD_Z; end
      ALU_OR:  begin bus.result = bus.a | bus.b; bus.upd = CPS_UPD_Z; end
      ALU_XOR: begin bus.result = bus.a ^ bus.b; bus.upd = CPS_UPD_Z; end
      ALU_CPL: begin bus.result = ~bus.a;        bus.upd = CPS_UPD_Z; end
      ALU_RR:  bus.result = {bus.a[0], bus.a[7:1]};
      ALU_RL:  bus.result = {bus.a[6:0], bus.a[7]};
      ALU_RRC: begin
        bus.result = {bus.cin, bus.a[7:1]};
        bus.flags[CPS_ST_C] = bus.a[0];
        bus.upd    = CPS_UPD_C;
      end
      ALU_RLC: begin
        bus.result = {bus.a[6:0], bus.cin};
        bus.flags[CPS_ST_C] = bus.a[7];
        bus.upd    = CPS_UPD_C;
      end
      ALU_INC: begin bus.result = bus.a + 8'h01; bus.upd = CPS_UPD_Z; end
      ALU_DEC: begin bus.result = bus.a - 8'h01; bus.upd = CPS_UPD_Z; end
      ALU_MOV: bus.result = bus.b;
      default: bus.result = bus.a;
    endcase
    bus.flags[CPS_ST_Z] = (bus.result == 8'h00);
  end
endmodule
`default_nettype wire

/* rtl/cps_stack.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_stack
  import cps_pkg::*;
#(
  parameter int DEPTH = CPS_STACK_DEPTH,  // return levels, power of two
  parameter int W     = CPS_PC_W          // saved address width
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rst,   // synchronous reset
  input  wire logic         push,  // save din
  input  wire logic         pop,   // drop the newest entry
  input  wire logic [W-1:0] din,   // address to save
  output logic      [W-1:0] dout,  // newest saved address
  output logic              full   // every level in use
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] ptr;
  logic [CW-1:0] count;
  logic [PW-1:0] top;

  assign top  = ptr - PW'(1);
  assign dout = mem[top];
  assign full = (count == CW'(DEPTH));

  // ring storage: a push when full lands on the oldest entry
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr   <= '0;
      count <= '0;
    end else if (push) begin
      mem[ptr] <= din;
      ptr      <= ptr + PW'(1);
      if (!full) begin
        count <= count + CW'(1);
      end
    end else if (pop && (count != '0)) begin
      ptr   <= top;
      count <= count - CW'(1);
    end
  end
endmodule
`default_nettype wire

/* rtl/cps_sequencer.sv */
// How it works
// - system clock split into four phases; four phases make one instruction cycle
// - at first phase the counter advances and a new word is fetched
// - phases two to four decode and execute the previously fetched word
// - fetch overlaps execute, so plain instructions take one cycle each
// - jumps and calls take two cycles: branch on the fourth phase, then the target fetch in a dummy cycle
// - counter steps by one unless control moves elsewhere
// - jumps, calls, interrupt entry and reset load the target directly
// - a taken skip discards the prefetched word, leaving a dummy cycle
// - only the low counter byte is software visible; upper bits are narrower
// - writing the low byte jumps inside the current 256-word page
// - every low-byte write inserts one dummy cycle for the refetch
// - hardware stack holds counter values only, two or four levels, hidden
// - stack pointer hidden; reset puts it at the top
// - a call or interrupt acknowledge pushes the counter
// - subroutine or interrupt return pops the stack into the counter
// - interrupt with full stack is held pending until a return frees a level
// - a call on a full stack still runs and loses the oldest entry
// - ALU writes its result and updates carry, borrow and other flags
// - ALU does add, subtract, adjust, logic, rotates, step and skip tests
// - reset restarts execution at address zero
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer
  import cps_pkg::*;
#(
  parameter int PC_W        = CPS_PC_W,         // 10 small variant, 11 large
  parameter int STACK_DEPTH = CPS_STACK_DEPTH   // 2 small variant, 4 large
) (
  input  wire logic                MCLK,       // system clock
  input  wire logic                SRST,       // synchronous reset, active high
  output logic      [PC_W-1:0]     PM_ADDR,    // program memory fetch address
  output logic                     PM_FETCH,   // fetch strobe, one cycle
  input  wire logic [CPS_IW-1:0]   PM_DATA,    // instruction word from memory
  input  wire logic                IRQ_REQ,    // enabled interrupt request pulse
  output logic                     INT_ACK,    // interrupt acknowledge pulse
  output logic                     CYCLE_T1,   // high during each first phase but the one after reset
  input  wire logic [CPS_RA_W-1:0] REG_ADDR,   // register address
  input  wire logic [7:0]          REG_WDATA,  // register write data
  input  wire logic                REG_WR,     // write strobe
  input  wire logic                REG_RD,     // read strobe
  output logic      [7:0]          REG_RDATA   // read data, cycle after strobe
);

  // phase sequencer
  cps_phase_t phase;
  cps_phase_t next_phase;

  // fetch and execute state
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   next_pc;
  logic [CPS_IW-1:0] fetched;
  logic              fetched_ok;
  logic [CPS_IW-1:0] ir;

  // data path state
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic [3:0] flags;
  logic [3:0] next_flags;

  // interrupt and low-byte write state
  logic       irq_flag;
  logic       next_irq_flag;
  logic       in_isr;
  logic       pcl_pend;
  logic       next_pcl_pend;
  logic [7:0] pcl_val;

  // decode
  cps_opc_t        opc;
  logic            is_exec;
  logic            is_jmp;
  logic            is_call;
  logic            is_ret;
  logic            is_interrupt_exit_instr;
  logic            is_movpcl;
  logic            alu_en;
  logic            skip_taken;
  logic            pcl_from_port;
  logic            pcl_jump;
  logic [7:0]      pcl_data;
  logic            irq_take;
  logic            flush;
  logic [PC_W-1:0] ret_addr;
  logic [PC_W-1:0] target;

  // stack link
  logic            stk_push;
  logic            stk_pop;
  logic [PC_W-1:0] stk_top;
  logic            stk_full;

  // register port decode
  logic       wr_pcl;
  logic       wr_acc;
  logic [7:0] rd_mux;
  logic [7:0] rd_data;

  cps_alu_if alu_bus ();

  cps_alu u_alu (
    .bus (alu_bus)
  );

  cps_stack #(
    .DEPTH (STACK_DEPTH),
    .W     (PC_W)
  ) u_stack (
    .clk  (MCLK),
    .rst  (SRST),
    .push (stk_push),
    .pop  (stk_pop),
    .din  (ret_addr),
    .dout (stk_top),
    .full (stk_full)
  );

  // jump, call and both returns claim the next slot themselves;
  // shared by the interrupt and the low-byte write arbitration
  function automatic logic is_transfer(input cps_opc_t code);
    case (code)
      OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT_INSTR: begin
        is_transfer = 1'b1;
      end
      default: begin
        is_transfer = 1'b0;
      end
    endcase
  endfunction

  // phase ring
  always_comb begin
    case (phase)
      CPS_T1:  next_phase = CPS_T2;
      CPS_T2:  next_phase = CPS_T3;
      CPS_T3:  next_phase = CPS_T4;
      CPS_T4:  next_phase = CPS_T1;
      default: next_phase = CPS_T1;
    endcase
  end

  // decode of the executing word; all effects land on the fourth phase
  assign opc        = cps_opc_t'(ir[15:12]);
  assign is_exec    = (phase == CPS_T4);
  assign is_jmp     = (opc == OP_JMP);
  assign is_call    = (opc == OP_CALL);
  assign is_interrupt_exit_instr    = (opc == OP_INTERRUPT_EXIT_INSTR);
  assign is_ret     = (opc == OP_RET) || is_interrupt_exit_instr;
  assign is_movpcl  = (opc == OP_MOVPCL);
  assign alu_en     = (opc == OP_ALU) || (opc == OP_SKIP);
  assign skip_taken = (opc == OP_SKIP) && alu_bus.flags[CPS_ST_Z];
  assign target     = ir[PC_W-1:0];

  // pc already points past the discarded prefetch, so step back one
  assign ret_addr   = pc - PC_W'(1);

  // a port write waits for a boundary that no other transfer owns;
  // applied under a jump it would be consumed and then lost
  assign pcl_from_port = pcl_pend && !is_movpcl && !is_transfer(opc) && !skip_taken;
  assign pcl_jump      = is_movpcl || pcl_from_port;
  assign pcl_data      = is_movpcl ? acc : pcl_val;

  // no entry while the stack is full or another transfer owns this boundary
  assign irq_take = irq_flag && !in_isr && !stk_full
                    && !is_transfer(opc) && !pcl_jump && !skip_taken;

  assign flush    = is_jmp || is_call || is_ret || pcl_jump || skip_taken || irq_take;

  assign stk_push = is_exec && (is_call || irq_take);
  assign stk_pop  = is_exec && is_ret;

  // next program counter at execute time
  always_comb begin
    next_pc = pc;
    if (is_jmp || is_call) begin
      next_pc = target;
    end else if (is_ret) begin
      next_pc = stk_top;
    end else if (pcl_jump) begin
      next_pc = {pc[PC_W-1:8], pcl_data};
    end else if (irq_take) begin
      next_pc = CPS_IRQ_VEC[PC_W-1:0];
    end
  end

  // ALU hookup
  assign alu_bus.op   = cps_aluop_t'(ir[11:8]);
  assign alu_bus.a    = acc;
  assign alu_bus.b    = ir[7:0];
  assign alu_bus.cin  = flags[CPS_ST_C];
  assign alu_bus.acin = flags[CPS_ST_AC];

  // register port decode
  assign wr_pcl = REG_WR && (REG_ADDR == CPS_OFS_PCL);
  assign wr_acc = REG_WR && (REG_ADDR == CPS_OFS_ACC);
  assign rd_mux = (REG_ADDR == CPS_OFS_PCL)    ? pc[7:0] :
                  (REG_ADDR == CPS_OFS_ACC)    ? acc :
                  (REG_ADDR == CPS_OFS_STATUS) ? {2'b00, in_isr, stk_full, flags} :
                  8'h00;
  // zero outside the answer cycle
  assign rd_data = REG_RD ? rd_mux : 8'h00;

  // accumulator: execute overrides a port write in the same cycle
  always_comb begin
    next_acc = acc;
    if (wr_acc) begin
      next_acc = REG_WDATA;
    end
    if (is_exec && alu_en) begin
      next_acc = alu_bus.result;
    end
  end

  always_comb begin
    next_flags = flags;
    if (is_exec && alu_en) begin
      next_flags = (flags & ~alu_bus.upd) | (alu_bus.flags & alu_bus.upd);
    end
  end

  // a new request beats the acknowledge clear
  assign next_irq_flag = IRQ_REQ || (irq_flag && !(is_exec && irq_take));

  // a new write beats consumption of the old one
  assign next_pcl_pend = wr_pcl || (pcl_pend && !(is_exec && pcl_from_port));

  // phase register and first-phase marker
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      phase    <= CPS_T1;
      CYCLE_T1 <= 1'b0;
    end else begin
      phase    <= next_phase;
      CYCLE_T1 <= (next_phase == CPS_T1);
    end
  end

  // fetch side: address and strobe launch on the first phase;
  // the address then stands for the whole instruction cycle
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PM_ADDR  <= CPS_RESET_VEC[PC_W-1:0];
      PM_FETCH <= 1'b0;
    end else begin
      PM_FETCH <= (phase == CPS_T1);
      if (phase == CPS_T1) begin
        PM_ADDR <= pc;
      end
    end
  end

  // program counter: step on the first phase, override on the fourth
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pc <= CPS_RESET_VEC[PC_W-1:0];
    end else if (phase == CPS_T1) begin
      pc <= pc + PC_W'(1);
    end else if (is_exec) begin
      pc <= next_pc;
    end
  end

  // prefetch and instruction register; a flushed prefetch becomes a dummy cycle
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      fetched    <= CPS_NOP_WORD;
      fetched_ok <= 1'b0;
      ir         <= CPS_NOP_WORD;
    end else begin
      case (phase)
        CPS_T1: begin
          ir         <= fetched_ok ? fetched : CPS_NOP_WORD;
          fetched_ok <= 1'b1;
        end
        CPS_T3: begin
          fetched <= PM_DATA;
        end
        CPS_T4: begin
          if (flush) begin
            fetched_ok <= 1'b0;
          end
        end
        default: begin
          fetched_ok <= fetched_ok;
        end
      endcase
    end
  end

  // accumulator and status flags
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      acc   <= CPS_ACC_RST;
      flags <= CPS_FLAGS_RST;
    end else begin
      acc   <= next_acc;
      flags <= next_flags;
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rd_data;
    end
  end

  // pending low-byte write from the register port
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pcl_pend <= 1'b0;
      pcl_val  <= 8'h00;
    end else begin
      pcl_pend <= next_pcl_pend;
      if (wr_pcl) begin
        pcl_val <= REG_WDATA;
      end
    end
  end

  // interrupt request, acknowledge and service marker;
  // the acknowledge pulses on the edge that pushes the return address
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      irq_flag <= 1'b0;
      in_isr   <= 1'b0;
      INT_ACK  <= 1'b0;
    end else begin
      irq_flag <= next_irq_flag;
      INT_ACK  <= is_exec && irq_take;
      if (is_exec && irq_take) begin
        in_isr <= 1'b1;
      end else if (is_exec && is_interrupt_exit_instr) begin
        in_isr <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* verification/cps_sequencer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer_sva
  import cps_pkg::*;
#(
  parameter int PC_W        = CPS_PC_W,
  parameter int STACK_DEPTH = CPS_STACK_DEPTH
) (
  input wire logic                MCLK,      // clock
  input wire logic                SRST,      // reset
  input wire logic [PC_W-1:0]     PM_ADDR,   // fetch address
  input wire logic                PM_FETCH,  // fetch strobe
  input wire logic [CPS_IW-1:0]   PM_DATA,   // fetched word
  input wire logic                IRQ_REQ,   // request
  input wire logic                INT_ACK,   // acknowledge
  input wire logic                CYCLE_T1,  // first phase
  input wire logic [CPS_RA_W-1:0] REG_ADDR,  // reg address
  input wire logic [7:0]          REG_WDATA, // write data
  input wire logic                REG_WR,    // write strobe
  input wire logic                REG_RD,    // read strobe
  input wire logic [7:0]          REG_RDATA  // read data
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  AST_FETCH_EVERY_FOUR: assert property (PM_FETCH |=> !PM_FETCH [*3] ##1 PM_FETCH)
    else $error("fetch strobe not every fourth cycle");
  AST_ADDR_HELD: assert property (PM_FETCH |=> $stable(PM_ADDR) [*3])
    else $error("fetch address moved inside its cycle");
  AST_T1_FETCH: assert property (CYCLE_T1 |=> PM_FETCH && !CYCLE_T1)
    else $error("no fetch after first phase");
  AST_RESET_VECTOR: assert property ($fell(SRST) |=> PM_FETCH && PM_ADDR == '0)
    else $error("first fetch after reset not at zero");
  AST_ACK_BOUNDARY: assert property (INT_ACK |-> CYCLE_T1)
    else $error("acknowledge off an instruction boundary");
  AST_ACK_VECTOR: assert property (INT_ACK |=> PM_FETCH && PM_ADDR == CPS_IRQ_VEC[PC_W-1:0])
    else $error("vector not fetched after acknowledge");
  AST_ACK_SINGLE: assert property (INT_ACK |=> !INT_ACK [*3])
    else $error("acknowledge repeated");
  AST_RDATA_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside its cycle");
  AST_UNMAPPED_READ: assert property (REG_RD && REG_ADDR > CPS_OFS_STATUS |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_STATUS_PAD: assert property (REG_RD && REG_ADDR == CPS_OFS_STATUS |=> REG_RDATA[7:6] == 2'b00)
    else $error("status pad bits set");
endmodule
bind cps_sequencer cps_sequencer_sva #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) u_sva (
  .MCLK(MCLK), .SRST(SRST), .PM_ADDR(PM_ADDR), .PM_FETCH(PM_FETCH), .PM_DATA(PM_DATA),
  .IRQ_REQ(IRQ_REQ), .INT_ACK(INT_ACK), .CYCLE_T1(CYCLE_T1), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
`default_nettype wire

/* verification/cps_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_prog_mem #(
  parameter int AW   = 11,   // address width
  parameter bit SLOW = 1'b1  // answer a cycle late
) (
  input  wire logic          clk,    // system clock
  input  wire logic          fetch,  // fetch strobe
  input  wire logic [AW-1:0] addr,   // fetch address
  output logic      [15:0]   data    // instruction word
);
  logic [15:0] mem [0:(1<<AW)-1];
  logic [1:0]  age = 2'd3;
  logic [15:0] last = 16'h0000;
  logic        valid;
  // word only stands up to the sampling edge two edges after the strobe
  assign valid = (age == 2'd1) || (fetch && !SLOW);
  // outside the window show the inverse so a late sample never matches
  assign data  = valid ? mem[addr] : ~last;
  always @(posedge clk) begin
    age <= fetch ? 2'd1 : (age == 2'd3 ? age : age + 2'd1);
    if (age == 2'd1) last <= mem[addr];
  end
endmodule
`default_nettype wire

/* verification/tb_cps_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cps_sequencer
  import cps_pkg::*;
;
  logic                mclk = 1'b0;
  logic                srst = 1'b1;
  logic                irq = 1'b0;
  logic                wr = 1'b0;
  logic                rd = 1'b0;
  logic [3:0]          ra = 4'h0;
  logic [7:0]          wd = 8'h00;
  logic [7:0]          rdata;
  logic [7:0]          d;
  logic [CPS_PC_W-1:0] pm_addr;
  logic                pm_fetch;
  logic                ack;
  logic [15:0]         pm_data;
  logic [CPS_PC_W-1:0] trace [$];
  int                  error_cnt = 0;
  int                  n_checks = 0;
  int                  k;
  logic                got;
  localparam logic [10:0] EXP [15] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h010, 11'h011, 11'h020,
    11'h021, 11'h011, 11'h012, 11'h013, 11'h014, 11'h015, 11'h014, 11'h015};

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (pm_fetch === 1'b1) trace.push_back(pm_addr);

  cps_sequencer u_dut (
    .MCLK(mclk), .SRST(srst), .PM_ADDR(pm_addr), .PM_FETCH(pm_fetch), .PM_DATA(pm_data),
    .IRQ_REQ(irq), .INT_ACK(ack), .CYCLE_T1(), .REG_ADDR(ra), .REG_WDATA(wd),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
  cps_prog_mem u_mem (.clk(mclk), .fetch(pm_fetch), .addr(pm_addr), .data(pm_data));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    ra <= a;
    wd <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    rd <= 1'b1;
    ra <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask

  task automatic pulse_irq();
    @(posedge mclk);
    irq <= 1'b1;
    @(posedge mclk);
    irq <= 1'b0;
  endtask

  task automatic wait_ack(input int n);
    int j;
    got = 1'b0;
    for (j = 0; j < n && got !== 1'b1; j++) begin
      @(posedge mclk);
      if (ack === 1'b1) got = 1'b1;
    end
  endtask

  // bounded so a stalled fetch stream cannot hang the run
  task automatic wait_fetch(input int n);
    int j;
    for (j = 0; j < 400 && trace.size() < n; j++) @(posedge mclk);
    if (trace.size() < n) begin
      check("fetch count", 16'(trace.size()), 16'(n));
      close_out();
    end
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    close_out();
  end

  initial begin
    for (k = 0; k < 2048; k++) u_mem.mem[k] = CPS_NOP_WORD;
    u_mem.mem[0] = {OP_ALU, ALU_MOV, 8'h05};
    u_mem.mem[1] = {OP_ALU, ALU_ADD, 8'hFB};
    u_mem.mem[2] = {OP_JMP, 12'h010};
    u_mem.mem[4] = {OP_INTERRUPT_EXIT_INSTR, 12'h000};
    u_mem.mem[16] = {OP_CALL, 12'h020};
    u_mem.mem[17] = {OP_SKIP, ALU_XOR, 8'h00};
    u_mem.mem[18] = {OP_ALU, ALU_MOV, 8'h77};
    u_mem.mem[19] = {OP_ALU, ALU_OR, 8'h30};
    u_mem.mem[20] = {OP_JMP, 12'h014};
    u_mem.mem[32] = {OP_RET, 12'h000};
    u_mem.mem[66] = {OP_JMP, 12'h042};
    // four nested calls leave every return level in use
    for (k = 0; k < 4; k++) u_mem.mem[80+k] = {OP_CALL, 12'(81 + k)};
    u_mem.mem[84] = {OP_JMP, 12'h054};
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rd_reg(CPS_OFS_ACC, d);
    check("acc reset", d, 8'h00);
    rd_reg(CPS_OFS_STATUS, d);
    check("status reset", d, 8'h00);
    $display("test reset done");
    wait_fetch(15);
    for (k = 0; k < 15; k++) check("fetch addr", trace[k], EXP[k]);
    rd_reg(CPS_OFS_ACC, d);
    check("acc result", d, 8'h30);
    rd_reg(CPS_OFS_STATUS, d);
    check("flags", d, 8'h03);
    rd_reg(CPS_OFS_PCL, d);
    check("pcl in loop", 16'(d >= 8'h14 && d <= 8'h16), 16'h0001);
    $display("test program flow done");
    trace.delete();
    wr_reg(CPS_OFS_PCL, 8'h40);
    wait_fetch(6);
    k = 0;
    while (k < 4 && trace[k] !== 11'h040) k++;
    check("page jump", trace[k], 11'h040);
    check("after jump", trace[k+1], 11'h041);
    $display("test page jump done");
    wr_reg(CPS_OFS_ACC, 8'h5A);
    rd_reg(CPS_OFS_ACC, d);
    check("acc write", d, 8'h5A);
    wr_reg(CPS_OFS_STATUS, 8'hFF);
    rd_reg(CPS_OFS_STATUS, d);
    check("status read only", d, 8'h03);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, d);
    check("unmapped", d, 8'h00);
    $display("test registers done");
    pulse_irq();
    wait_ack(40);
    check("ack", got, 1'b1);
    rd_reg(CPS_OFS_STATUS, d);
    check("in isr", d[5], 1'b1);
    repeat (20) @(posedge mclk);
    rd_reg(CPS_OFS_STATUS, d);
    check("isr left", d[5], 1'b0);
    $display("test interrupt done");
    wr_reg(CPS_OFS_PCL, 8'h50);
    repeat (60) @(posedge mclk);
    rd_reg(CPS_OFS_STATUS, d);
    check("stack full", d[4], 1'b1);
    pulse_irq();
    wait_ack(60);
    check("ack held", got, 1'b0);
    u_mem.mem[84] = {OP_RET, 12'h000};
    wait_ack(60);
    check("ack freed", got, 1'b1);
    $display("test full stack done");
    close_out();
  end
endmodule
`default_nettype wire
